//--- verilog/swpc_port_policy.sv
`timescale 1ns/1ps
module swpc_port_policy (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] prog_ctrl,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic congested,
	input wire logic rx_pause_frame,
	input wire logic rx_frame,
	input wire logic phy_link,
	input wire logic an_done,
	input wire logic an_speed10,
	input wire logic an_half,
	output logic link_up,
	output logic an_run,
	output logic mii_poll,
	output logic speed_10,
	output logic half_duplex,
	output logic tx_jam,
	output logic tx_pause_req,
	output logic rx_pause_apply,
	output logic rx_forward,
	output logic rx_learn,
	output logic rx_drop,
	output logic [swpc_pkg::CNT_W-1:0] fc_rx_count
);

	logic [7:0] act_q, act_d;
	logic link_d, an_run_d, mii_poll_d, speed_d, half_d;
	logic jam_d, pause_d, apply_d, fwd_d, learn_d, drop_d;
	logic [swpc_pkg::CNT_W-1:0] cnt_d;
	logic fc_on, pause_ok;
	swpc_pkg::swpc_mode_t mode;
	swpc_pkg::swpc_stp_t stp;

	always_comb begin
		mode = swpc_pkg::swpc_mode_t'(act_q[swpc_pkg::MODE_MSB:swpc_pkg::MODE_LSB]);
		stp = swpc_pkg::swpc_stp_t'(act_q[swpc_pkg::STP_MSB:swpc_pkg::STP_LSB]);
		// RQ18 frame boundary commit
		act_d = (tx_active || rx_active) ? act_q : prog_ctrl;
		// RQ1 flow control polarity
		fc_on = !act_q[swpc_pkg::FC_OFF_BIT];
		speed_d = act_q[swpc_pkg::SPEED10_BIT];
		half_d = act_q[swpc_pkg::HALF_BIT];
		an_run_d = 1'b0;
		mii_poll_d = 1'b0;
		link_d = 1'b0;
		unique case (mode)
			// RQ9 hardware auto negotiation
			swpc_pkg::MODE_AUTO: begin
				an_run_d = 1'b1;
				link_d = phy_link && an_done;
				if (an_done) begin
					speed_d = an_speed10;
					half_d = an_half;
				end
			end
			// RQ10 poll only, no speed negotiation
			swpc_pkg::MODE_LIMITED: begin
				mii_poll_d = 1'b1;
				link_d = phy_link;
			end
			// RQ11 forced link down
			swpc_pkg::MODE_DOWN: begin
				link_d = 1'b0;
			end
			// RQ12 forced up from low control bits
			swpc_pkg::MODE_UP: begin
				link_d = 1'b1;
			end
		endcase
		// RQ2 back pressure in half duplex; RQ5 none when off
		jam_d = link_d && fc_on && half_d && congested;
		// RQ3 pause frames in full duplex; RQ13 asymmetric suppresses them
		pause_d = link_d && fc_on && !half_d && !act_q[swpc_pkg::ASYM_BIT] && congested;
		// RQ6 received pause ignored when flow control is off
		pause_ok = link_d && fc_on && !half_d && rx_pause_frame;
		apply_d = pause_ok;
		// RQ4 count received pause frames, saturating
		cnt_d = (pause_ok && fc_rx_count != swpc_pkg::CNT_MAX) ? fc_rx_count + swpc_pkg::CNT_ONE : fc_rx_count;
		// RQ14 RQ15 RQ16 spanning tree filtering
		fwd_d = link_d && rx_frame && (stp == swpc_pkg::STP_FORWARDING);
		learn_d = link_d && rx_frame && act_q[swpc_pkg::STP_MSB];
		drop_d = rx_frame && !fwd_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			act_q <= swpc_pkg::CTRL_RESET;
			link_up <= 1'b0;
			an_run <= 1'b0;
			mii_poll <= 1'b0;
			speed_10 <= 1'b0;
			half_duplex <= 1'b0;
			tx_jam <= 1'b0;
			tx_pause_req <= 1'b0;
			rx_pause_apply <= 1'b0;
			rx_forward <= 1'b0;
			rx_learn <= 1'b0;
			rx_drop <= 1'b0;
			fc_rx_count <= '0;
		end else begin
			act_q <= act_d;
			link_up <= link_d;
			an_run <= an_run_d;
			mii_poll <= mii_poll_d;
			speed_10 <= speed_d;
			half_duplex <= half_d;
			tx_jam <= jam_d;
			tx_pause_req <= pause_d;
			rx_pause_apply <= apply_d;
			rx_forward <= fwd_d;
			rx_learn <= learn_d;
			rx_drop <= drop_d;
			fc_rx_count <= cnt_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_jam_cause;
		tx_jam |-> $past(fc_on) && $past(half_d) && $past(congested);
	endproperty
	a_jam_cause: assert property (p_jam_cause) else $error("jam without flow control in half duplex"); // RQ2

	property p_pause_cause;
		tx_pause_req |-> $past(fc_on) && !$past(half_d) && !$past(act_q[swpc_pkg::ASYM_BIT]);
	endproperty
	a_pause_cause: assert property (p_pause_cause) else $error("pause frame request not allowed"); // RQ13

	property p_cnt_inc;
		$past(pause_ok) && $past(fc_rx_count) != swpc_pkg::CNT_MAX |-> fc_rx_count == $past(fc_rx_count) + 1;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("pause counter missed a frame"); // RQ4

	property p_cnt_hold;
		!$past(fc_on) |-> $stable(fc_rx_count) && !rx_pause_apply;
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("pause counted while flow control off"); // RQ6

	property p_link_down;
		$past(mode) == swpc_pkg::MODE_DOWN |-> !link_up && !an_run;
	endproperty
	a_link_down: assert property (p_link_down) else $error("link up in forced down mode"); // RQ11

	property p_link_up;
		$past(mode) == swpc_pkg::MODE_UP |-> link_up ##0 speed_10 == $past(act_q[swpc_pkg::SPEED10_BIT]);
	endproperty
	a_link_up: assert property (p_link_up) else $error("forced up mode not applied"); // RQ12

	property p_forward;
		rx_forward |-> $past(stp) == swpc_pkg::STP_FORWARDING && rx_learn;
	endproperty
	a_forward: assert property (p_forward) else $error("frame forwarded outside forwarding state"); // RQ16

	property p_learning;
		$past(rx_frame && link_d && stp == swpc_pkg::STP_LEARNING) |-> rx_learn && rx_drop && !rx_forward;
	endproperty
	a_learning: assert property (p_learning) else $error("learning state handled wrongly"); // RQ15

	property p_commit;
		$past(tx_active || rx_active) |-> act_q == $past(act_q);
	endproperty
	a_commit: assert property (p_commit) else $error("control changed inside a frame"); // RQ18

	c_jam: cover property (tx_jam);
	c_pause_counted: cover property (pause_ok ##1 rx_pause_apply);
	c_learn_drop: cover property (rx_learn && rx_drop);

endmodule // swpc_port_policy

//--- shared/swpc_pkg.sv
package swpc_pkg;

	// Port population and register address map
	localparam int unsigned NPORTS = 27;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] CPU_BASE = 12'h000;
	localparam logic [11:0] I2C_BASE = 12'h000;
	localparam logic [11:0] I2C_LAST = 12'h01A;
	localparam logic [10:0] CPU_PORT_LIMIT = 11'h01B;

	// Control byte layout
	localparam int unsigned FC_OFF_BIT = 0;
	localparam int unsigned HALF_BIT = 1;
	localparam int unsigned SPEED10_BIT = 2;
	localparam int unsigned MODE_LSB = 3;
	localparam int unsigned MODE_MSB = 4;
	localparam int unsigned ASYM_BIT = 5;
	localparam int unsigned STP_LSB = 6;
	localparam int unsigned STP_MSB = 7;
	localparam logic [7:0] CTRL_RESET = 8'hC0;

	// Received pause frame counter
	localparam int unsigned CNT_W = 16;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;

	typedef enum logic [1:0] {
		MODE_AUTO = 2'b00,
		MODE_LIMITED = 2'b01,
		MODE_DOWN = 2'b10,
		MODE_UP = 2'b11
	} swpc_mode_t;

	typedef enum logic [1:0] {
		STP_BLOCKING = 2'b00,
		STP_LISTENING = 2'b01,
		STP_LEARNING = 2'b10,
		STP_FORWARDING = 2'b11
	} swpc_stp_t;

	// Returns {hit, port index}; CPU space uses even addresses only
	function automatic logic [IDX_W:0] swpc_decode(input logic i2c, input logic [11:0] addr);
		logic [11:0] off;
		logic hit;
		logic [IDX_W-1:0] idx;
		off = 12'h000;
		hit = 1'b0;
		idx = '0;
		if (i2c) begin
			off = addr - I2C_BASE;
			hit = (addr >= I2C_BASE) && (off <= (I2C_LAST - I2C_BASE));
			idx = off[IDX_W-1:0];
		end else begin
			off = addr - CPU_BASE;
			hit = (addr >= CPU_BASE) && (off[0] == 1'b0) && (off[11:1] < CPU_PORT_LIMIT);
			idx = off[IDX_W:1];
		end
		return {hit, idx};
	endfunction

endpackage

//--- verilog/swpc_port_ctrl.sv
// Notes on behaviour
// RQ1: Control bit 0 set turns flow control off; clear turns it on.
// RQ2: Flow control on in half duplex jams collisions as back pressure.
// RQ3: Flow control on in full duplex sends and honours pause frames.
// RQ4: With flow control on, each received pause frame bumps the counter; the code counts them only in full duplex with link up.
// RQ5: Flow control off in half duplex: no pause frames, no jamming.
// RQ6: Flow control off in full duplex: no pause, received pause ignored, uncounted.
// RQ7: Bit 1 picks half duplex when set, full duplex when clear.
// RQ8: Bit 2 picks 10 Mb/s when set, 100 Mb/s when clear.
// RQ9: Mode 00 runs the hardware auto-negotiation machine.
// RQ10: Mode 01 skips speed negotiation but still polls PHY link.
// RQ11: Mode 10 stops negotiation and holds the link down.
// RQ12: Mode 11 forces link up using bits 2:0 for configuration.
// RQ13: Asymmetric bit stops pause transmission yet keeps pause reception; resets clear.
// RQ14: Spanning state resets to forwarding; blocking and listening drop frames.
// RQ15: Learning state drops frames but learns their source addresses.
// RQ16: Forwarding state forwards frames and learns source addresses.
// RQ17: One register per port, CPU address 2N, I2C address N, both writable.
// RQ18: Control changes apply only between frames.
`timescale 1ns/1ps
module swpc_port_ctrl (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic CFG_I2C,
	input wire logic [swpc_pkg::ADDR_W-1:0] CFG_ADDR,
	input wire logic [7:0] CFG_WDATA,
	output logic [7:0] CFG_RDATA,
	output logic CFG_RVALID,
	input wire logic [swpc_pkg::NPORTS-1:0] TX_ACTIVE,
	input wire logic [swpc_pkg::NPORTS-1:0] RX_ACTIVE,
	input wire logic [swpc_pkg::NPORTS-1:0] CONGESTED,
	input wire logic [swpc_pkg::NPORTS-1:0] RX_PAUSE_FRAME,
	input wire logic [swpc_pkg::NPORTS-1:0] RX_FRAME,
	input wire logic [swpc_pkg::NPORTS-1:0] PHY_LINK,
	input wire logic [swpc_pkg::NPORTS-1:0] AN_DONE,
	input wire logic [swpc_pkg::NPORTS-1:0] AN_SPEED10,
	input wire logic [swpc_pkg::NPORTS-1:0] AN_HALF,
	output logic [swpc_pkg::NPORTS-1:0] LINK_UP,
	output logic [swpc_pkg::NPORTS-1:0] AN_RUN,
	output logic [swpc_pkg::NPORTS-1:0] MII_POLL,
	output logic [swpc_pkg::NPORTS-1:0] SPEED_10,
	output logic [swpc_pkg::NPORTS-1:0] HALF_DUPLEX,
	output logic [swpc_pkg::NPORTS-1:0] TX_JAM,
	output logic [swpc_pkg::NPORTS-1:0] TX_PAUSE_REQ,
	output logic [swpc_pkg::NPORTS-1:0] RX_PAUSE_APPLY,
	output logic [swpc_pkg::NPORTS-1:0] RX_FORWARD,
	output logic [swpc_pkg::NPORTS-1:0] RX_LEARN,
	output logic [swpc_pkg::NPORTS-1:0] RX_DROP,
	output logic [swpc_pkg::NPORTS*swpc_pkg::CNT_W-1:0] FC_RX_COUNT
);

	// Programmed control bytes, one per port; readback shows these, not the active copy
	logic [7:0] ctrl_q [swpc_pkg::NPORTS];
	logic [7:0] ctrl_d [swpc_pkg::NPORTS];
	logic [7:0] rdata_d;
	logic rvalid_d;
	logic [swpc_pkg::IDX_W:0] dec;
	logic hit;
	logic [swpc_pkg::IDX_W-1:0] idx;

	always_comb begin
		// RQ17 address decode
		dec = swpc_pkg::swpc_decode(CFG_I2C, CFG_ADDR);
		hit = dec[swpc_pkg::IDX_W];
		idx = dec[swpc_pkg::IDX_W-1:0];
	end

	always_comb begin
		for (int i = 0; i < swpc_pkg::NPORTS; i++) begin
			ctrl_d[i] = ctrl_q[i];
		end
		// RQ17 per-port write
		if (CFG_WR && hit) begin
			ctrl_d[idx] = CFG_WDATA;
		end
		// A read in the same cycle as a write returns the old value; data holds between reads
		rdata_d = CFG_RDATA;
		if (CFG_RD) begin
			rdata_d = hit ? ctrl_q[idx] : 8'h00;
		end
		rvalid_d = CFG_RD;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			// RQ14 spanning state resets to forwarding
			for (int i = 0; i < swpc_pkg::NPORTS; i++) begin
				ctrl_q[i] <= swpc_pkg::CTRL_RESET;
			end
			CFG_RDATA <= 8'h00;
			CFG_RVALID <= 1'b0;
		end else begin
			for (int i = 0; i < swpc_pkg::NPORTS; i++) begin
				ctrl_q[i] <= ctrl_d[i];
			end
			CFG_RDATA <= rdata_d;
			CFG_RVALID <= rvalid_d;
		end
	end

	// RQ7 RQ8 duplex and speed applied per port
	for (genvar p = 0; p < swpc_pkg::NPORTS; p++) begin : g_port
		swpc_port_policy u_policy (
			.clk(REF_CLK),
			.rst_n(RSTN),
			.prog_ctrl(ctrl_q[p]),
			.tx_active(TX_ACTIVE[p]),
			.rx_active(RX_ACTIVE[p]),
			.congested(CONGESTED[p]),
			.rx_pause_frame(RX_PAUSE_FRAME[p]),
			.rx_frame(RX_FRAME[p]),
			.phy_link(PHY_LINK[p]),
			.an_done(AN_DONE[p]),
			.an_speed10(AN_SPEED10[p]),
			.an_half(AN_HALF[p]),
			.link_up(LINK_UP[p]),
			.an_run(AN_RUN[p]),
			.mii_poll(MII_POLL[p]),
			.speed_10(SPEED_10[p]),
			.half_duplex(HALF_DUPLEX[p]),
			.tx_jam(TX_JAM[p]),
			.tx_pause_req(TX_PAUSE_REQ[p]),
			.rx_pause_apply(RX_PAUSE_APPLY[p]),
			.rx_forward(RX_FORWARD[p]),
			.rx_learn(RX_LEARN[p]),
			.rx_drop(RX_DROP[p]),
			.fc_rx_count(FC_RX_COUNT[p*swpc_pkg::CNT_W +: swpc_pkg::CNT_W])
		);
	end

	default clocking cb @(posedge REF_CLK); endclocking

	property p_reset_value;
		$past(!RSTN) && RSTN |-> ctrl_q[0] == swpc_pkg::CTRL_RESET && !CFG_RVALID;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("control byte not at reset value"); // RQ14

	property p_write_lands;
		disable iff (!RSTN)
		$past(CFG_WR && hit) |-> ctrl_q[$past(idx)] == $past(CFG_WDATA);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("register write lost"); // RQ17

	property p_read_back;
		disable iff (!RSTN)
		CFG_RD && hit && !CFG_WR |=> CFG_RVALID && CFG_RDATA == ctrl_q[$past(idx)];
	endproperty
	a_read_back: assert property (p_read_back) else $error("readback mismatch"); // RQ17

	property p_unmapped;
		disable iff (!RSTN)
		CFG_RD && !hit |=> CFG_RVALID && CFG_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // RQ17

	property p_cpu_odd;
		disable iff (!RSTN)
		!CFG_I2C && CFG_ADDR[0] |-> !hit;
	endproperty
	a_cpu_odd: assert property (p_cpu_odd) else $error("odd CPU address decoded as port"); // RQ17

	c_cpu_write: cover property (disable iff (!RSTN) CFG_WR && hit && !CFG_I2C);
	c_i2c_read: cover property (disable iff (!RSTN) CFG_RD && hit && CFG_I2C ##1 CFG_RVALID);

endmodule // swpc_port_ctrl

//--- dv/swpc_phy_model.sv
`timescale 1ns/1ps
module swpc_phy_model #(
	parameter int DELAY = 3
) (
	input wire logic clk,
	input wire logic [swpc_pkg::NPORTS-1:0] an_run,
	input wire logic [swpc_pkg::NPORTS-1:0] link_cut,
	output logic [swpc_pkg::NPORTS-1:0] phy_link,
	output logic [swpc_pkg::NPORTS-1:0] an_done,
	output logic [swpc_pkg::NPORTS-1:0] an_speed10,
	output logic [swpc_pkg::NPORTS-1:0] an_half
);
	logic [swpc_pkg::NPORTS-1:0] sh_q [DELAY];
	// Negotiation ends DELAY cycles after it starts; a stop restarts the wait
	always_ff @(posedge clk) begin
		sh_q[0] <= an_run;
		for (int i = 1; i < DELAY; i++) begin
			sh_q[i] <= sh_q[i-1] & an_run;
		end
	end
	assign an_done = sh_q[DELAY-1] & an_run;
	// Link loss only where a scenario cuts the cable
	assign phy_link = ~link_cut;
	assign an_speed10 = '0;
	assign an_half = '0;
endmodule // swpc_phy_model

//--- dv/swpc_port_ctrl_bench.sv
`timescale 1ns/1ps
module swpc_port_ctrl_bench;
	localparam int N = swpc_pkg::NPORTS;
	logic clk, rstn, wr, rd, i2c, rvalid;
	logic [11:0] addr;
	logic [7:0] wdata, rdata;
	logic [N-1:0] tx_act, rx_act, cong, rx_pause, rx_frame, link_cut, phy_link, an_done, an_s10, an_hd;
	logic [N-1:0] link_up, an_run, mii_poll, speed_10, half_dup, tx_jam, pause_req, pause_apply, fwd, learn, drop;
	logic [N*16-1:0] cnt;
	int errors = 0;
	int tests_run = 0;

	swpc_port_ctrl dut (.REF_CLK(clk), .RSTN(rstn), .CFG_WR(wr), .CFG_RD(rd), .CFG_I2C(i2c), .CFG_ADDR(addr),
		.CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .TX_ACTIVE(tx_act), .RX_ACTIVE(rx_act),
		.CONGESTED(cong), .RX_PAUSE_FRAME(rx_pause), .RX_FRAME(rx_frame), .PHY_LINK(phy_link),
		.AN_DONE(an_done), .AN_SPEED10(an_s10), .AN_HALF(an_hd), .LINK_UP(link_up), .AN_RUN(an_run),
		.MII_POLL(mii_poll), .SPEED_10(speed_10), .HALF_DUPLEX(half_dup), .TX_JAM(tx_jam),
		.TX_PAUSE_REQ(pause_req), .RX_PAUSE_APPLY(pause_apply), .RX_FORWARD(fwd), .RX_LEARN(learn),
		.RX_DROP(drop), .FC_RX_COUNT(cnt));
	swpc_phy_model #(.DELAY(3)) phy (.clk(clk), .an_run(an_run), .link_cut(link_cut), .phy_link(phy_link),
		.an_done(an_done), .an_speed10(an_s10), .an_half(an_hd));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cfg_wr(input logic sel, input logic [11:0] a, input logic [7:0] d);
		i2c = sel;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		@(negedge clk);
	endtask

	task automatic cfg_rd(input logic sel, input logic [11:0] a, input logic [7:0] exp);
		int k;
		i2c = sel;
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		k = 0;
		while (rvalid !== 1'b1 && k < 3) begin
			@(negedge clk);
			k++;
		end
		chk("rvalid", {15'h0000, rvalid}, 16'h0001);
		chk("rdata", {8'h00, rdata}, {8'h00, exp});
		@(negedge clk);
	endtask

	// Write by CPU address and let the byte reach the outputs
	task automatic cfg(input int p, input logic [7:0] d);
		cfg_wr(1'b0, 12'(2 * p), d);
		repeat (4) @(negedge clk);
	endtask

	task automatic t_reset();
		repeat (6) @(negedge clk);
		cfg_rd(1'b0, 12'h000, 8'hC0);
		chk("an_run", 16'(an_run[5]), 16'h0001);
		chk("link_up", 16'(link_up[5]), 16'h0001);
	endtask

	task automatic t_map();
		cfg_wr(1'b0, 12'h000, 8'h80);
		cfg_wr(1'b0, 12'h01A, 8'h8D);
		cfg_wr(1'b1, 12'h01A, 8'h9A);
		cfg_wr(1'b0, 12'h036, 8'h55);
		cfg_rd(1'b1, 12'h000, 8'h80);
		cfg_rd(1'b1, 12'h00D, 8'h8D);
		cfg_rd(1'b0, 12'h034, 8'h9A);
		cfg_rd(1'b0, 12'h001, 8'h00);
		cfg_rd(1'b1, 12'h01B, 8'h00);
		cfg_rd(1'b0, 12'h036, 8'h00);
	endtask

	task automatic t_modes();
		cfg(1, 8'hC8);
		link_cut[1] = 1'b1;
		repeat (2) @(negedge clk);
		chk("mii_poll", 16'({an_run[1], mii_poll[1], link_up[1]}), 16'h0002);
		link_cut[1] = 1'b0;
		repeat (2) @(negedge clk);
		chk("link_up", 16'(link_up[1]), 16'h0001);
		cfg(1, 8'hD0);
		chk("link_down", 16'({an_run[1], link_up[1]}), 16'h0000);
		cfg(1, 8'hDE);
		chk("forced", 16'({link_up[1], speed_10[1], half_dup[1]}), 16'h0007);
		cfg(1, 8'hD8);
		chk("forced", 16'({link_up[1], speed_10[1], half_dup[1]}), 16'h0004);
	endtask

	// Entry: control byte, pause request, jam, pause honoured
	task automatic t_flow();
		logic [10:0] tbl [5] = '{{8'hD8, 3'b101}, {8'hDA, 3'b010}, {8'hD9, 3'b000}, {8'hDB, 3'b000},
			{8'hF8, 3'b001}};
		logic [15:0] exp_cnt;
		exp_cnt = 16'h0000;
		cong[2] = 1'b1;
		for (int i = 0; i < 5; i++) begin
			cfg(2, tbl[i][10:3]);
			chk("pause_req", 16'(pause_req[2]), 16'(tbl[i][2]));
			chk("tx_jam", 16'(tx_jam[2]), 16'(tbl[i][1]));
			rx_pause[2] = 1'b1;
			@(negedge clk);
			rx_pause[2] = 1'b0;
			chk("pause_apply", 16'(pause_apply[2]), 16'(tbl[i][0]));
			@(negedge clk);
			exp_cnt = exp_cnt + 16'(tbl[i][0]);
			chk("fc_count", cnt[32 +: 16], exp_cnt);
		end
		cong[2] = 1'b0;
	endtask

	task automatic t_stp();
		for (int s = 0; s < 4; s++) begin
			cfg(3, {2'(s), 6'h18});
			rx_frame[3] = 1'b1;
			@(negedge clk);
			rx_frame[3] = 1'b0;
			chk("stp", {drop[3], fwd[3], learn[3]}, {13'h0000, s != 3, s == 3, s >= 2});
			@(negedge clk);
		end
	endtask

	task automatic t_busy();
		tx_act[4] = 1'b1;
		cfg(4, 8'hD0);
		repeat (2) @(negedge clk);
		chk("busy_hold", 16'(link_up[4]), 16'h0001);
		tx_act[4] = 1'b0;
		repeat (3) @(negedge clk);
		chk("idle_commit", 16'(link_up[4]), 16'h0000);
	endtask

	initial begin
		#(50 * 4000);
		errors++;
		complete_run();
	end

	initial begin
		{rstn, wr, rd, i2c, addr, wdata} = '0;
		{tx_act, rx_act, cong, rx_pause, rx_frame, link_cut} = '0;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_map();
		t_modes();
		t_flow();
		t_stp();
		t_busy();
		complete_run();
	end
endmodule // swpc_port_ctrl_bench
